/* pkg/plk_cfg.svh */
// Constants for the PHY/MAC clocking and link-mode ends
// Notes on behaviour
// - Straps set start-up configuration, no management needed
// - Management clock never above 2.5 MHz
// - Management turnaround at least one bit time
// - Control bit 14 loops transmit back to receive
// - 10/100: TX_CLK captures and sends line data
// - 1000: GTX_CLK only captures MAC data
// - Gigabit line clock: master internal, slave recovered
// - Test clock pin shows line clock, modes 2/3
// - Unused TX_CLK and RXD[7:4] driven low
// - 25 MHz on both clocks during auto-negotiation
// - Link clocks: 2.5/25 MHz; gigabit only receive clock
// - Forced 10/100 partner: parallel detect, half duplex
// - Gigabit needs both negotiating or forced master/slave
`ifndef PLK_CFG_SVH
`define PLK_CFG_SVH

// ----------------------------------------------------------------
// Control word and test mode fields
// ----------------------------------------------------------------
`define PLK_CTL_ADDR 5'h00
`define PLK_CTL_LOOPBACK_BIT 14
`define PLK_TEST_MODE_JITTER_A 3'h2
`define PLK_TEST_MODE_JITTER_B 3'h3

// ----------------------------------------------------------------
// Timing, in MHz or kHz and derived cycle counts at the system clock
// ----------------------------------------------------------------
`define PLK_SYS_CLK_MHZ 125
`define PLK_AN_CLK_MHZ 25
`define PLK_CLK_10_KHZ 2500
`define PLK_CLK_100_MHZ 25
`define PLK_DIV_AN (`PLK_SYS_CLK_MHZ / `PLK_AN_CLK_MHZ)
`define PLK_DIV_100 (`PLK_SYS_CLK_MHZ / `PLK_CLK_100_MHZ)
`define PLK_DIV_10 ((`PLK_SYS_CLK_MHZ * 1000) / `PLK_CLK_10_KHZ)
`define PLK_AN_SETTLE_CYC 64

`endif

/* pkg/plk_pkg.sv */
// Types shared by both link ends
`default_nettype none
package plk_pkg;
	typedef enum logic [1:0] {PLK_SPD_10, PLK_SPD_100, PLK_SPD_1000} plk_speed_t;
endpackage
`default_nettype wire

/* pkg/plk_mii_if.sv */
// MII/GMII carrier between the PHY end and the MAC end
`timescale 1ns/1ps
`default_nettype none
interface plk_mii_if;
	logic tx_clk;
	logic rx_clk;
	logic gtx_clk;
	logic [7:0] txd;
	logic tx_en;
	logic tx_er;
	logic tx_ready;
	logic [7:0] rxd;
	logic rx_dv;
	logic rx_er;
	modport phy (output tx_clk, rx_clk, tx_ready, rxd, rx_dv, rx_er,
		input gtx_clk, txd, tx_en, tx_er);
	modport mac (input tx_clk, rx_clk, tx_ready, rxd, rx_dv, rx_er,
		output gtx_clk, txd, tx_en, tx_er);
endinterface // plk_mii_if
`default_nettype wire

/* hw/plk_phy_end.sv */
// PHY end: strap start-up, link resolution, MII/GMII clocking, loopback
`timescale 1ns/1ps
`default_nettype none
`include "plk_cfg.svh"

// ----------------------------------------------------------------
// Two-entry buffer with registered ready
// ----------------------------------------------------------------
module plk_buf2 #(
	parameter int W = 9
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	logic [W-1:0] mem [2];
	logic wr_q;
	logic rd_q;
	logic [1:0] cnt_q;
	logic [1:0] cnt_d;
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = out_ready && (cnt_q != 2'h0);
	assign out_valid = (cnt_q != 2'h0);
	assign out_data = mem[rd_q];
	assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};

	// Storage; no reset needed on data
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_q] <= in_data;
	end

	// Pointers and fill level; ready looks ahead so at least one more push fits
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			cnt_q <= 2'h0;
			in_ready <= 1'b0;
		end
		else
		begin
			if (push)
				wr_q <= ~wr_q;
			if (pop)
				rd_q <= ~rd_q;
			cnt_q <= cnt_d;
			in_ready <= (cnt_d <= 2'h1);
		end
	end
endmodule // plk_buf2

// ----------------------------------------------------------------
// PHY end
// ----------------------------------------------------------------
module plk_phy_end (
	input wire logic clk,
	input wire logic rst,
	plk_mii_if.phy mii,
	input wire logic strap_an_en,
	input wire plk_pkg::plk_speed_t strap_speed,
	input wire logic strap_master,
	input wire logic strap_tclk_en,
	input wire logic [15:0] ctl_word,
	input wire logic [2:0] test_mode,
	input wire logic partner_present,
	input wire logic partner_an,
	input wire plk_pkg::plk_speed_t partner_speed,
	input wire logic partner_master,
	input wire logic line_rec_tick,
	input wire logic [7:0] line_rxd,
	input wire logic line_rx_dv,
	input wire logic line_rx_er,
	output logic [7:0] line_txd,
	output logic line_tx_en,
	output logic line_tx_er,
	output logic line_tx_clock_monitor,
	output logic link_up,
	output plk_pkg::plk_speed_t link_speed,
	output logic link_full_duplex
);
	import plk_pkg::*;

	typedef enum logic [1:0] {ST_STRAP, ST_NEGOTIATE, ST_LINK} plk_state_t;

	plk_state_t state_q;
	logic an_en_q;
	plk_speed_t strap_spd_q;
	logic master_q;
	logic tclk_en_q;
	logic [6:0] an_cnt_q;
	logic res_ok;
	plk_speed_t res_spd;
	logic res_fdx;
	logic gig;
	logic loop;
	logic [5:0] div_q;
	logic [5:0] div_max;
	logic tick;
	logic cap;
	logic ltick;
	logic pop;
	logic buf_valid;
	logic [8:0] buf_data;

	assign gig = link_up && (link_speed == PLK_SPD_1000);
	assign loop = ctl_word[`PLK_CTL_LOOPBACK_BIT];

	// ------------------------------------------------------------
	// Start-up and link state
	// ------------------------------------------------------------

	// Straps caught once, on the first edge after reset release
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			an_en_q <= 1'b1;
			strap_spd_q <= PLK_SPD_1000;
			master_q <= 1'b0;
			tclk_en_q <= 1'b0;
		end
		else if (state_q == ST_STRAP)
		begin
			an_en_q <= strap_an_en;
			strap_spd_q <= strap_speed;
			master_q <= strap_master;
			tclk_en_q <= strap_tclk_en;
		end
	end

	// Resolve against the partner; gigabit never parallel-detects
	always_comb
	begin
		res_ok = 1'b0;
		res_spd = strap_spd_q;
		res_fdx = 1'b1;
		if (partner_present)
		begin
			if (an_en_q && partner_an)
				res_ok = 1'b1;
			else if (an_en_q && (partner_speed != PLK_SPD_1000))
			begin
				res_ok = 1'b1;
				res_spd = partner_speed;
				res_fdx = 1'b0;
			end
			else if (!an_en_q && !partner_an && (strap_spd_q == PLK_SPD_1000))
				res_ok = (partner_speed == PLK_SPD_1000) && (partner_master != master_q);
			else if (!an_en_q && !partner_an)
				res_ok = (partner_speed == strap_spd_q);
		end
	end

	// Link state machine; negotiation runs a fixed settle time then resolves
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_q <= ST_STRAP;
			an_cnt_q <= 7'h00;
			link_up <= 1'b0;
			link_speed <= PLK_SPD_10;
			link_full_duplex <= 1'b0;
		end
		else
		begin
			case (state_q)
				ST_STRAP:
				begin
					state_q <= ST_NEGOTIATE;
					an_cnt_q <= 7'h00;
				end
				ST_NEGOTIATE:
				begin
					if (an_cnt_q == 7'(`PLK_AN_SETTLE_CYC - 1))
					begin
						an_cnt_q <= 7'h00;
						if (res_ok)
						begin
							state_q <= ST_LINK;
							link_up <= 1'b1;
							link_speed <= res_spd;
							link_full_duplex <= res_fdx;
						end
					end
					else
						an_cnt_q <= an_cnt_q + 7'h01;
				end
				ST_LINK:
				begin
					if (!partner_present)
					begin
						state_q <= ST_NEGOTIATE;
						link_up <= 1'b0;
					end
				end
				default:
					state_q <= ST_STRAP;
			endcase
		end
	end

	// ------------------------------------------------------------
	// MII clocks as enable pulses
	// ------------------------------------------------------------

	// Divider period follows state and speed
	always_comb
	begin
		div_max = 6'(`PLK_DIV_AN - 1);
		if (link_up)
		begin
			case (link_speed)
				PLK_SPD_10: div_max = 6'(`PLK_DIV_10 - 1);
				PLK_SPD_100: div_max = 6'(`PLK_DIV_100 - 1);
				default: div_max = 6'h00;
			endcase
		end
	end

	assign tick = (div_q == 6'h00);

	// Divider; restarts cleanly whenever the period shrinks under it
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			div_q <= 6'h00;
		else if (tick || (div_q > div_max))
			div_q <= div_max;
		else
			div_q <= div_q - 6'h01;
	end

	// TX_CLK idles low at gigabit, RX_CLK always runs
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			mii.tx_clk <= 1'b0;
			mii.rx_clk <= 1'b0;
		end
		else
		begin
			mii.tx_clk <= tick && !gig;
			mii.rx_clk <= tick;
		end
	end

	// ------------------------------------------------------------
	// Transmit path
	// ------------------------------------------------------------

	// Capture clock: TX_CLK below gigabit, GTX_CLK at gigabit
	assign cap = gig ? mii.gtx_clk : mii.tx_clk;
	// Line clock: never GTX_CLK; gigabit master internal, slave recovered
	assign ltick = gig ? (master_q ? 1'b1 : line_rec_tick) : mii.tx_clk;
	assign pop = loop ? mii.rx_clk : ltick;

	// Buffer absorbs a line-side stall without losing a MAC word
	plk_buf2 #(.W(9)) u_txbuf (
		.clk(clk),
		.rst(rst),
		.in_valid(cap && link_up && (mii.tx_en || mii.tx_er)),
		.in_data({mii.tx_er, gig ? mii.txd : {4'h0, mii.txd[3:0]}}),
		.in_ready(mii.tx_ready),
		.out_valid(buf_valid),
		.out_data(buf_data),
		.out_ready(pop)
	);

	// Line transmit; stays idle during loopback
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			line_txd <= 8'h00;
			line_tx_en <= 1'b0;
			line_tx_er <= 1'b0;
		end
		else if (loop)
		begin
			line_txd <= 8'h00;
			line_tx_en <= 1'b0;
			line_tx_er <= 1'b0;
		end
		else if (ltick)
		begin
			line_txd <= buf_valid ? buf_data[7:0] : 8'h00;
			line_tx_en <= buf_valid;
			line_tx_er <= buf_valid && buf_data[8];
		end
	end

	// Test clock shows the gigabit line clock, forced on in jitter modes
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			line_tx_clock_monitor <= 1'b0;
		else
			line_tx_clock_monitor <= gig && ltick && (tclk_en_q
				|| (test_mode == `PLK_TEST_MODE_JITTER_A)
				|| (test_mode == `PLK_TEST_MODE_JITTER_B));
	end

	// ------------------------------------------------------------
	// Receive path
	// ------------------------------------------------------------

	// Loopback returns buffered MAC data; upper nibble low below gigabit
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			mii.rxd <= 8'h00;
			mii.rx_dv <= 1'b0;
			mii.rx_er <= 1'b0;
		end
		else if (!link_up)
		begin
			mii.rxd <= 8'h00;
			mii.rx_dv <= 1'b0;
			mii.rx_er <= 1'b0;
		end
		else if (mii.rx_clk && loop)
		begin
			mii.rxd <= buf_valid ? buf_data[7:0] : 8'h00;
			mii.rx_dv <= buf_valid;
			mii.rx_er <= buf_valid && buf_data[8];
		end
		else if (mii.rx_clk)
		begin
			mii.rxd <= gig ? line_rxd : {4'h0, line_rxd[3:0]};
			mii.rx_dv <= line_rx_dv;
			mii.rx_er <= line_rx_er;
		end
	end
endmodule // plk_phy_end
`default_nettype wire

/* hw/plk_mac_end.sv */
// MAC end: drives GTX_CLK at gigabit and moves words over MII/GMII
`timescale 1ns/1ps
`default_nettype none

module plk_mac_end (
	input wire logic clk,
	input wire logic rst,
	plk_mii_if.mac mii,
	input wire plk_pkg::plk_speed_t mac_speed,
	input wire logic [7:0] usr_tx_data,
	input wire logic usr_tx_err,
	input wire logic usr_tx_valid,
	output logic usr_tx_ready,
	output logic [7:0] usr_rx_data,
	output logic usr_rx_valid,
	output logic usr_rx_err
);
	import plk_pkg::*;

	logic gig;
	logic adv;
	logic buf_valid;
	logic [8:0] buf_data;

	assign gig = (mac_speed == PLK_SPD_1000);
	// A word moves on each transmit clock pulse the PHY can accept
	assign adv = (gig ? mii.gtx_clk : mii.tx_clk) && mii.tx_ready;

	// User words wait here while the PHY stalls
	plk_buf2 #(.W(9)) u_usrbuf (
		.clk(clk),
		.rst(rst),
		.in_valid(usr_tx_valid),
		.in_data({usr_tx_err, usr_tx_data}),
		.in_ready(usr_tx_ready),
		.out_valid(buf_valid),
		.out_data(buf_data),
		.out_ready(adv)
	);

	// GTX_CLK pulses every cycle at gigabit only
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			mii.gtx_clk <= 1'b0;
		else
			mii.gtx_clk <= gig;
	end

	// Transmit beat held until the next accepted clock pulse
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			mii.txd <= 8'h00;
			mii.tx_en <= 1'b0;
			mii.tx_er <= 1'b0;
		end
		else if (adv)
		begin
			mii.txd <= buf_valid ? buf_data[7:0] : 8'h00;
			mii.tx_en <= buf_valid;
			mii.tx_er <= buf_valid && buf_data[8];
		end
	end

	// Receive beats handed to the user as one-cycle pulses
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			usr_rx_data <= 8'h00;
			usr_rx_valid <= 1'b0;
			usr_rx_err <= 1'b0;
		end
		else
		begin
			usr_rx_valid <= mii.rx_clk && mii.rx_dv;
			usr_rx_err <= mii.rx_clk && mii.rx_er;
			if (mii.rx_clk)
				usr_rx_data <= mii.rxd;
		end
	end
endmodule // plk_mac_end
`default_nettype wire

/* sim/plk_link_properties.sv */
// Property checker for the MII/GMII carrier between both ends
`timescale 1ns/1ps
`default_nettype none
module plk_link_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic tx_clk,
	input wire logic rx_clk,
	input wire logic gtx_clk,
	input wire logic [7:0] txd,
	input wire logic tx_en,
	input wire logic tx_er,
	input wire logic tx_ready,
	input wire logic [7:0] rxd,
	input wire logic rx_dv,
	input wire logic rx_er
);
	// ------------------------------------
	// Clock shape, unused lines, data hold
	// ------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// TX_CLK runs no faster than 25 MHz, with RX_CLK pulsing beside it
	property p_tx_gap;
		tx_clk |=> !tx_clk [*4];
	endproperty
	a_tx_gap: assert property (p_tx_gap)
		else $error("tx_clk pulses too close");
	property p_clk_pair;
		tx_clk ##5 tx_clk |-> rx_clk || $past(rx_clk) || $past(rx_clk, 2)
			|| $past(rx_clk, 3) || $past(rx_clk, 4);
	endproperty
	a_clk_pair: assert property (p_clk_pair)
		else $error("rx_clk missing beside tx_clk");
	// Gigabit: receive clock every cycle, transmit clock parked low; below gigabit RXD[7:4] low
	property p_gig_rx;
		rx_clk [*2] |=> rx_clk;
	endproperty
	a_gig_rx: assert property (p_gig_rx)
		else $error("gigabit rx_clk stopped");
	property p_gig_tx;
		rx_clk [*3] |-> !tx_clk;
	endproperty
	a_gig_tx: assert property (p_gig_tx)
		else $error("tx_clk active at gigabit");
	property p_nib;
		rx_clk ##1 !rx_clk |-> rxd[7:4] == 4'h0;
	endproperty
	a_nib: assert property (p_nib)
		else $error("upper receive nibble not low");
	// MAC holds a word until a capture edge with room
	property p_hold;
		(tx_en || tx_er) && !((tx_clk || gtx_clk) && tx_ready)
			|=> $stable({txd, tx_en, tx_er});
	endproperty
	a_hold: assert property (p_hold)
		else $error("transmit word moved without capture");
	// Receive lines move only beside a receive clock pulse
	property p_rx_upd;
		!$stable({rxd, rx_dv}) |-> rx_clk || $past(rx_clk);
	endproperty
	a_rx_upd: assert property (p_rx_upd)
		else $error("receive data moved off rx_clk");
	property p_er_upd;
		$changed(rx_er) |-> rx_clk || $past(rx_clk);
	endproperty
	a_er_upd: assert property (p_er_upd)
		else $error("rx_er moved off rx_clk");
endmodule // plk_link_chk
`default_nettype wire

/* sim/plk_link_tb.sv */
// Self-checking bench joining the PHY end and the MAC end
`timescale 1ns/1ps
`default_nettype none
module plk_link_tb;
	import plk_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic an = 1'b0, mst = 1'b0, tce = 1'b0, pan = 1'b0, pms = 1'b0, pres = 1'b1;
	logic rtk = 1'b0, tv = 1'b0, te = 1'b0, lrv = 1'b0, lre = 1'b0;
	logic [7:0] td = 8'h00, lrd = 8'h00;
	logic [15:0] ctl = 16'h0000;
	logic [2:0] tmd = 3'h0;
	plk_speed_t spd = PLK_SPD_10, psp = PLK_SPD_10, msp = PLK_SPD_10;
	plk_speed_t lsp;
	logic [7:0] ltd, rd;
	logic lte, lter, mon, lnk, fdx, trdy, rv, re;
	logic [31:0] seed = 32'h9dc2ad17;
	int miscompares = 0;
	int n_compared = 0;
	int nmon = 0;
	logic [8:0] eq[$], sq[$], rq[$], lq[$];

	// ------------------------------------
	// Design, carrier and checker
	// ------------------------------------
	plk_mii_if mi ();
	plk_phy_end plk_phy_end_i (.clk(clk), .rst(rst), .mii(mi), .strap_an_en(an),
		.strap_speed(spd), .strap_master(mst), .strap_tclk_en(tce), .ctl_word(ctl),
		.test_mode(tmd), .partner_present(pres), .partner_an(pan), .partner_speed(psp),
		.partner_master(pms), .line_rec_tick(rtk), .line_rxd(lrd), .line_rx_dv(lrv),
		.line_rx_er(lre), .line_txd(ltd), .line_tx_en(lte), .line_tx_er(lter),
		.line_tx_clock_monitor(mon), .link_up(lnk), .link_speed(lsp),
		.link_full_duplex(fdx));
	plk_mac_end plk_mac_end_i (.clk(clk), .rst(rst), .mii(mi), .mac_speed(msp),
		.usr_tx_data(td), .usr_tx_err(te), .usr_tx_valid(tv), .usr_tx_ready(trdy),
		.usr_rx_data(rd), .usr_rx_valid(rv), .usr_rx_err(re));
	plk_link_chk plk_link_chk_i (.clk(clk), .rst(rst), .tx_clk(mi.tx_clk),
		.rx_clk(mi.rx_clk), .gtx_clk(mi.gtx_clk), .txd(mi.txd), .tx_en(mi.tx_en),
		.tx_er(mi.tx_er), .tx_ready(mi.tx_ready), .rxd(mi.rxd), .rx_dv(mi.rx_dv),
		.rx_er(mi.rx_er));

	always #4 clk = ~clk;
	// Collect words; slave recovered clock ticks every other cycle
	always @(negedge clk)
	begin
		rtk <= ~rtk;
		nmon <= nmon + int'(mon);
		if (rv)
			rq.push_back({re, rd});
		if (lte)
			lq.push_back({lter, ltd});
	end

	// ------------------------------------
	// Helpers
	// ------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Word as it crosses the carrier: upper nibble dropped below gigabit
	function automatic logic [8:0] mii_word(input logic [8:0] v, input int s);
		return (s == 2) ? v : {v[8], 4'h0, v[3:0]};
	endfunction
	function automatic logic sig(input logic r);
		return r ? mi.rx_clk : mi.tx_clk;
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Cycles between two clock pulses, 200 when none
	task automatic per(input logic r, output int p);
		int i;
		for (i = 0; i < 200 && !sig(r); i++)
			@(negedge clk);
		@(negedge clk);
		for (p = 1; p < 200 && !sig(r); p++)
			@(negedge clk);
	endtask
	task automatic results;
		if (miscompares == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// One strap and partner setup, from reset to traffic
	task automatic run(input logic a, input int s, input logic m, input logic pa,
		input int ps, input logic pm, input logic lp, input logic [2:0] tm,
		input logic tc, input logic lk);
		int p, w, es, n0, rp, lt;
		logic [8:0] v;
		es = (a && !pa) ? ps : s;
		// Receive clock period and line clock period, in cycles
		rp = (es == 2) ? 1 : (es == 1) ? 5 : 50;
		lt = (es == 2) ? (m ? 1 : 2) : rp;
		@(negedge clk);
		rst = 1'b1;
		{an, mst, pan, pms, tce, tmd} = {a, m, pa, pm, tc, tm};
		spd = plk_speed_t'(s);
		psp = plk_speed_t'(ps);
		msp = plk_speed_t'(es);
		ctl = {1'b0, lp, 14'h0000};
		repeat (10) @(negedge clk);
		rst = 1'b0;
		per(1'b0, p);
		chk(16'(p), 16'd5);
		per(1'b1, p);
		chk(16'(p), 16'd5);
		for (w = 0; w < 300 && !lnk; w++)
			@(negedge clk);
		chk(16'(lnk), 16'(lk));
		if (!lk)
			return;
		chk(16'({lsp, fdx}), 16'({es[1:0], !(a && !pa)}));
		repeat (2) per(1'b0, p);
		chk(16'(p), es == 0 ? 16'd50 : es == 1 ? 16'd5 : 16'd200);
		repeat (2) per(1'b1, p);
		chk(16'(p), es == 0 ? 16'd50 : es == 1 ? 16'd5 : 16'd1);
		n0 = nmon;
		repeat (40) @(negedge clk);
		w = (es == 2 && (tc || tm == 3'h2 || tm == 3'h3)) ? (m ? 40 : 20) : 0;
		chk(16'(nmon - n0), 16'(w));
		eq.delete();
		sq.delete();
		rq.delete();
		lq.delete();
		// Random words into the MAC, held until accepted
		for (int k = 0; k < 8; k++)
		begin
			seed = lfsr(seed);
			v = mii_word(seed[8:0], es);
			sq.push_back(v);
			if (lp)
				eq.push_back(v);
			{te, td} = seed[8:0];
			tv = 1'b1;
			for (w = 0; w < 400 && !trdy; w++)
				@(negedge clk);
			@(negedge clk);
		end
		tv = 1'b0;
		// Line receive words, each held one receive clock period
		for (int k = 0; k < 6 && !lp; k++)
		begin
			seed = lfsr(seed);
			{lre, lrd} = seed[8:0];
			lrv = 1'b1;
			eq.push_back(mii_word(seed[8:0], es));
			repeat (rp) @(negedge clk);
		end
		lrv = 1'b0;
		repeat (800) @(negedge clk);
		chk(16'(rq.size()), 16'(eq.size()));
		foreach (eq[k])
			chk(16'(rq[k]), 16'(eq[k]));
		// Each line word stands one line clock period, so it is seen lt times
		chk(16'(lq.size()), lp ? 16'd0 : 16'(8 * lt));
		if (!lp)
			foreach (sq[k])
				chk(16'(lq[k * lt]), 16'(sq[k]));
	endtask

	// ------------------------------------
	// Watchdog and main sequence
	// ------------------------------------
	initial
	begin
		#500000;
		miscompares++;
		results();
	end
	initial
	begin
		run(1, 1, 0, 1, 0, 0, 1, 3'h0, 0, 1);
		run(1, 1, 0, 0, 0, 0, 1, 3'h0, 0, 1);
		run(1, 2, 0, 0, 1, 0, 1, 3'h0, 0, 1);
		run(1, 2, 0, 0, 2, 0, 1, 3'h0, 0, 0);
		run(0, 0, 0, 0, 0, 0, 1, 3'h0, 0, 1);
		run(1, 1, 0, 0, 1, 0, 0, 3'h0, 0, 1);
		run(0, 2, 1, 0, 2, 0, 0, 3'h0, 1, 1);
		run(0, 2, 1, 0, 2, 1, 0, 3'h0, 0, 0);
		run(0, 2, 0, 0, 2, 1, 0, 3'h2, 0, 1);
		run(0, 2, 1, 0, 2, 0, 1, 3'h3, 0, 1);
		run(1, 2, 1, 1, 0, 0, 1, 3'h0, 0, 1);
		results();
	end
endmodule // plk_link_tb
`default_nettype wire
